//--- hdl/dsm_modulator_top.sv
// clock selection, modulator clock and four bitstream channels
// Notes on behaviour
// RULE_01 - select high: internal 20 MHz clock source
// RULE_02 - select low: external 1 to 32 MHz
// RULE_03 - modulator clock is system clock halved
// RULE_04 - external input static while internal selected
// RULE_05 - one output clock shared by all channels
// RULE_06 - one bit per modulator clock per channel
// RULE_07 - density 50/80/20 percent at 0/+2/-2 V
// RULE_08 - feedback follows decision on next clock
// RULE_09 - receiver low-pass filters and decimates
// RULE_10 - receiver uses third-order sinc, ratio 16-256
// RULE_11 - word rate is modulator clock over ratio
// RULE_12 - receiver data clock is clock over ratio
// RULE_13 - sinc3 settles in three, sinc2 two
// RULE_14 - fast overcurrent path uses second-order sinc
// RULE_15 - fast variant adds input delayed 2*ratio
// RULE_16 - receiver may cascade two filter stages
// RULE_17 - four outputs, one per channel A-D
// RULE_18 - receiver maps one +1, zero -1
// RULE_19 - receiver samples bits with shared clock
`timescale 1ns/1ns
module dsm_modulator_top
	import dsm_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  reset,
	input  wire logic                  clock_source_select,
	input  wire logic                  external_clock_input,
	input  wire dsm_pkg::dsm_samples_t channel_input,
	output dsm_pkg::dsm_link_t         link
);
	dsm_clk_state_t s_r;
	dsm_clk_state_t s_nxt;
	logic           ext_rise;
	logic [DSM_CHANNELS-1:0] bits;

	// synchronised edge of the external clock
	assign ext_rise = s_r.ext_s2 & ~s_r.ext_prev;

	// system clock pick and divide by two
	always_comb begin
		s_nxt          = s_r;
		s_nxt.sel_s1   = clock_source_select;
		s_nxt.sel_s2   = s_r.sel_s1;
		s_nxt.ext_s1   = external_clock_input;
		s_nxt.ext_s2   = s_r.ext_s1;
		s_nxt.ext_prev = s_r.ext_s2;
		s_nxt.tick     = 1'b0;
		if (s_r.sel_s2) begin
			// internal oscillator, external pin ignored
			if (s_r.div_cnt == DSM_CNT_LAST) begin // RULE_01
				s_nxt.div_cnt = '0;
				s_nxt.mod_clk = ~s_r.mod_clk; // RULE_03
				s_nxt.tick    = ~s_r.mod_clk;
			end else begin
				s_nxt.div_cnt = s_r.div_cnt + 1'b1;
			end
		end else begin
			s_nxt.div_cnt = '0;
			if (ext_rise) begin // RULE_02
				s_nxt.mod_clk = ~s_r.mod_clk; // RULE_03
				s_nxt.tick    = ~s_r.mod_clk;
			end
		end
	end

	// state register
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r <= DSM_CLK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// one modulator per channel, all on the shared tick
	genvar ch;
	generate
		for (ch = 0; ch < DSM_CHANNELS; ch++) begin : g_chan
			dsm_mod_chan u_chan (
				.clock   (clock),
				.reset   (reset),
				.tick    (s_r.tick),
				.sample  (channel_input[ch]),
				.bit_out (bits[ch])
			); // RULE_17
		end
	endgenerate

	// pins: one clock for all streams
	assign link.shared_modulator_clock_output = s_r.mod_clk; // RULE_05
	assign link.channel_bitstream_output      = bits;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	localparam int PERIOD = 2 * DSM_HALF_CNT;

	a_int_period: assert property ((s_r.tick && s_r.sel_s2 && $past(s_r.sel_s2, PERIOD)
		&& $past(s_r.sel_s1, PERIOD)) |-> $past(s_r.tick, PERIOD))
		else $error("internal modulator period is not ten clocks"); // RULE_01
	a_int_gap:    assert property ((s_r.tick && s_r.sel_s2) |=> !s_r.tick [*4])
		else $error("internal tick repeated too early"); // RULE_03
	a_ext_follow: assert property ((!s_r.sel_s2 && ext_rise) |=>
		(s_r.mod_clk != $past(s_r.mod_clk)))
		else $error("external edge did not toggle modulator clock"); // RULE_02
	a_ext_static: assert property ((!s_r.sel_s2 && !ext_rise) |=> $stable(s_r.mod_clk))
		else $error("modulator clock moved without external edge"); // RULE_03
	a_tick_rise:  assert property (s_r.tick |-> (link.shared_modulator_clock_output
		&& !$past(link.shared_modulator_clock_output)))
		else $error("tick not aligned to rising output clock"); // RULE_05
	a_out_map:    assert property (link.channel_bitstream_output == bits)
		else $error("channel output not driven by its modulator"); // RULE_17
	c_int_tick:   cover property (s_r.sel_s2 && s_r.tick);
	c_ext_tick:   cover property (!s_r.sel_s2 && s_r.tick);
	c_mode_swap:  cover property ($fell(s_r.sel_s2) ##[1:50] s_r.tick);
endmodule // dsm_modulator_top

//--- hdl/dsm_pkg.sv
// shared constants and types for the four-channel bitstream modulator
package dsm_pkg;
	// clock rates in hertz
	localparam int unsigned DSM_CLK_HZ     = 100_000_000;
	localparam int unsigned DSM_OSC_HZ     = 20_000_000;
	localparam int unsigned DSM_EXT_MIN_HZ = 1_000_000;
	localparam int unsigned DSM_EXT_MAX_HZ = 32_000_000;
	// system clock to modulator clock ratio
	localparam int unsigned DSM_MOD_DIV    = 2;
	// fast clocks per half period of the modulator clock in internal mode
	localparam int unsigned DSM_HALF_CNT   = DSM_CLK_HZ / DSM_OSC_HZ * DSM_MOD_DIV / 2;
	localparam int unsigned DSM_CNT_W      = 4;
	localparam logic [DSM_CNT_W-1:0] DSM_CNT_LAST = DSM_CNT_W'(DSM_HALF_CNT - 1);

	// ideal ones density in percent at 0 V, +2 V and -2 V
	localparam int unsigned DSM_DENS_ZERO_PCT = 50;
	localparam int unsigned DSM_DENS_POS_PCT  = 80;
	localparam int unsigned DSM_DENS_NEG_PCT  = 20;
	// input code scaling: feedback is +-2^(in_w-1), so 2 V is this share of it
	localparam int unsigned DSM_TWO_VOLT_PCT  = (DSM_DENS_POS_PCT - DSM_DENS_NEG_PCT) / 2 * 2;

	// channel and datapath widths
	localparam int unsigned DSM_CHANNELS = 4;
	localparam int unsigned DSM_IN_W     = 16;
	localparam int unsigned DSM_INT_W    = 22;

	// zero-input density check window, in modulator ticks
	localparam int unsigned DSM_WIN_W    = 6;
	localparam int unsigned DSM_WIN_TOL  = 4;

	typedef logic signed [DSM_IN_W-1:0]  dsm_sample_t;
	typedef dsm_sample_t [DSM_CHANNELS-1:0] dsm_samples_t;
	typedef logic signed [DSM_INT_W-1:0] dsm_acc_t;

	// pins toward the decimating logic
	typedef struct packed {
		logic                    shared_modulator_clock_output;
		logic [DSM_CHANNELS-1:0] channel_bitstream_output;
	} dsm_link_t;

	// clock generation state
	typedef struct packed {
		logic                 sel_s1;
		logic                 sel_s2;
		logic                 ext_s1;
		logic                 ext_s2;
		logic                 ext_prev;
		logic [DSM_CNT_W-1:0] div_cnt;
		logic                 mod_clk;
		logic                 tick;
	} dsm_clk_state_t;

	// one modulator channel state
	typedef struct packed {
		dsm_acc_t integ1;
		dsm_acc_t integ2;
		logic     bit_out;
	} dsm_chan_state_t;

	localparam dsm_clk_state_t  DSM_CLK_RST  = '0;
	localparam dsm_chan_state_t DSM_CHAN_RST = '0;
endpackage

//--- hdl/dsm_mod_chan.sv
// one second-order delta-sigma modulator channel with 1-bit feedback
`timescale 1ns/1ns
module dsm_mod_chan
	import dsm_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              tick,
	input  wire dsm_pkg::dsm_sample_t sample,
	output logic                   bit_out
);
	// full-scale feedback level of the 1-bit converter
	localparam dsm_acc_t FS = dsm_acc_t'(1) <<< (DSM_IN_W - 1);

	dsm_chan_state_t s_r;
	dsm_chan_state_t s_nxt;
	dsm_acc_t        fb;
	dsm_acc_t        x_ext;

	// integrators step once per modulator tick
	always_comb begin
		s_nxt = s_r;
		x_ext = dsm_acc_t'(sample);
		fb    = s_r.bit_out ? FS : -FS; // RULE_08
		if (tick) begin
			s_nxt.integ1  = s_r.integ1 + x_ext - fb;
			s_nxt.integ2  = s_r.integ2 + s_nxt.integ1 - fb;
			s_nxt.bit_out = ~s_nxt.integ2[DSM_INT_W-1]; // RULE_06
		end
	end

	// state register
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r <= DSM_CHAN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bit_out = s_r.bit_out;

	// density window helper for zero input
	logic [DSM_WIN_W-1:0] win_r;
	logic [DSM_WIN_W:0]   ones_r;
	logic                 zero_r;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			win_r  <= '0;
			ones_r <= '0;
			zero_r <= 1'b1;
		end else if (tick) begin
			win_r  <= win_r + 1'b1;
			ones_r <= (win_r == '0) ? (DSM_WIN_W+1)'(s_r.bit_out)
				: ones_r + (DSM_WIN_W+1)'(s_r.bit_out);
			zero_r <= (win_r == '0) ? (sample == '0) : (zero_r & (sample == '0));
		end
	end

	localparam int unsigned WIN_HALF = (1 << DSM_WIN_W) * DSM_DENS_ZERO_PCT / 100;
	localparam logic [DSM_WIN_W:0] ONES_LO = (DSM_WIN_W+1)'(WIN_HALF - DSM_WIN_TOL);
	localparam logic [DSM_WIN_W:0] ONES_HI = (DSM_WIN_W+1)'(WIN_HALF + DSM_WIN_TOL);

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_bit_hold:   assert property (!tick |=> $stable(bit_out))
		else $error("bitstream changed without a modulator tick"); // RULE_06
	a_bit_sign:   assert property (tick |=> bit_out == !s_r.integ2[DSM_INT_W-1])
		else $error("bit does not follow integrator sign"); // RULE_08
	a_zero_dens:  assert property ((tick && win_r == '1 && zero_r && sample == '0)
		|=> (ones_r >= ONES_LO && ones_r <= ONES_HI))
		else $error("zero input density far from half"); // RULE_07
	c_bit_one:    cover property (tick ##1 bit_out);
endmodule // dsm_mod_chan

//--- sim/dsm_rx_model.sv
// receiver model: samples each bitstream once per period and sums +1/-1
`timescale 1ns/1ns
module dsm_rx_model
	import dsm_pkg::*;
#(
	parameter int OSR = 16 // low ratio inside 16..256
)
(
	input  wire logic               clock,
	input  wire logic               clear,
	input  wire dsm_pkg::dsm_link_t link,
	output int                      acc [DSM_CHANNELS],
	output int                      periods,
	output int                      word3 [DSM_CHANNELS],
	output int                      word2 [DSM_CHANNELS],
	output int                      wordf [DSM_CHANNELS],
	output int                      wordc [DSM_CHANNELS],
	output int                      words
);
	int i1  [DSM_CHANNELS];
	int i2  [DSM_CHANNELS];
	int i3  [DSM_CHANNELS];
	int c1  [DSM_CHANNELS];
	int c2  [DSM_CHANNELS];
	int c3  [DSM_CHANNELS];
	int g1  [DSM_CHANNELS];
	int g2  [DSM_CHANNELS];
	int s2a [DSM_CHANNELS];
	int s2b [DSM_CHANNELS];
	int d1;
	int d2;
	int e1;
	int e2;
	int ph;
	logic oclk_r = 1'b0;
	// take all channels on the shared clock fall, bits are settled by then
	always @(posedge clock) begin
		oclk_r <= link.shared_modulator_clock_output;
		if (clear) begin
			periods <= 0;
			foreach (acc[k]) acc[k] <= 0;
		end else if (oclk_r && !link.shared_modulator_clock_output) begin
			periods <= periods + 1;
			foreach (acc[k]) acc[k] <= acc[k] + (link.channel_bitstream_output[k] ? 1 : -1);
		end
	end

	// sinc3, sinc2, fast sinc2 and a two-word second stage per channel
	always @(posedge clock) begin
		if (clear) begin
			ph = 0;
			words = 0;
			foreach (i1[k]) begin
				i1[k] = 0;
				i2[k] = 0;
				i3[k] = 0;
				c1[k] = 0;
				c2[k] = 0;
				c3[k] = 0;
				g1[k] = 0;
				g2[k] = 0;
				s2a[k] = 0;
				s2b[k] = 0;
				word3[k] = 0;
				word2[k] = 0;
				wordf[k] = 0;
				wordc[k] = 0;
			end
		end else if (oclk_r && !link.shared_modulator_clock_output) begin
			foreach (i1[k]) begin
				i1[k] = i1[k] + (link.channel_bitstream_output[k] ? 1 : -1);
				i2[k] = i2[k] + i1[k];
				i3[k] = i3[k] + i2[k];
			end
			ph = ph + 1;
			if (ph == OSR) begin
				ph = 0;
				words = words + 1;
				foreach (i1[k]) begin
					d1 = i3[k] - c1[k];
					c1[k] = i3[k];
					d2 = d1 - c2[k];
					c2[k] = d1;
					wordc[k] = word3[k] + (d2 - c3[k]);
					word3[k] = d2 - c3[k];
					c3[k] = d2;
					e1 = i2[k] - g1[k];
					g1[k] = i2[k];
					e2 = e1 - g2[k];
					g2[k] = e1;
					word2[k] = e2;
					wordf[k] = e2 + s2b[k];
					s2b[k] = s2a[k];
					s2a[k] = e2;
				end
			end
		end
	end
endmodule // dsm_rx_model

//--- sim/dsm_bitstream_clock_and_decimation_tb.sv
// self-checking bench for clock selection, output clock rate and densities
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp %0d got %0d", nm, e, g); miscompares++; end end
module dsm_bitstream_clock_and_decimation_tb;
	import dsm_pkg::*;
	logic                    clock = 1'b0;
	logic                    reset = 1'b1;
	logic                    sel = 1'b1;
	logic                    ext = 1'b0;
	logic                    ext_run = 1'b0;
	logic                    clear = 1'b1;
	int                      ext_half = 5;
	int                      ext_cnt = 0;
	dsm_samples_t            chin = '0;
	dsm_link_t               link;
	int                      acc [DSM_CHANNELS];
	int                      periods;
	int                      word3 [DSM_CHANNELS];
	int                      word2 [DSM_CHANNELS];
	int                      wordf [DSM_CHANNELS];
	int                      wordc [DSM_CHANNELS];
	int                      words;
	int                      miscompares = 0;
	int                      n_checks = 0;
	int                      bad_upd = 0;
	int                      since = 0;
	logic                    oclk_q = 1'b0;
	logic [DSM_CHANNELS-1:0] bits_q = '0;

	dsm_modulator_top u_dut (.clock(clock), .reset(reset), .clock_source_select(sel),
		.external_clock_input(ext), .channel_input(chin), .link(link));
	dsm_rx_model u_rx (.clock(clock), .clear(clear), .link(link), .acc(acc), .periods(periods),
		.word3(word3), .word2(word2), .wordf(wordf), .wordc(wordc), .words(words));

	// 100 MHz system clock
	initial forever #5 clock = ~clock;

	// external clock source, held still while internal mode is selected
	always @(negedge clock) begin
		if (ext_run) begin
			ext_cnt <= (ext_cnt + 1 >= ext_half) ? 0 : ext_cnt + 1;
			if (ext_cnt + 1 >= ext_half) ext <= ~ext;
		end
	end

	// bits may only move on the cycle right after an output clock rise
	always @(negedge clock) begin
		oclk_q <= link.shared_modulator_clock_output;
		bits_q <= link.channel_bitstream_output;
		since <= (link.shared_modulator_clock_output && !oclk_q) ? 0 : since + 1;
		if (!reset && bits_q !== link.channel_bitstream_output && since != 0) bad_upd++;
	end

	task automatic stop_test;
		if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// output clock period in system clocks, over two periods after settling
	task automatic t_period(input int exp);
		int n;
		int r;
		logic p;
		n = 0;
		r = 0;
		p = link.shared_modulator_clock_output;
		repeat (2000) begin
			@(negedge clock);
			if (r > 1) n++;
			if (link.shared_modulator_clock_output && !p) r++;
			p = link.shared_modulator_clock_output;
			if (r == 4) break;
		end
		`CHK("period", 2 * exp, n)
	endtask

	// zero, +2 V and -2 V codes on separate channels, summed over 200 bits
	task automatic t_density;
		int e [DSM_CHANNELS] = '{0, 120, -120, 0};
		int pm [DSM_CHANNELS] = '{0, int'(2 * DSM_DENS_POS_PCT) - 100,
			int'(2 * DSM_DENS_NEG_PCT) - 100, 0};
		int x;
		chin = {16'h0000, 16'hb333, 16'h4ccd, 16'h0000};
		repeat (100) @(negedge clock);
		clear = 1'b1;
		@(negedge clock);
		clear = 1'b0;
		repeat (5000) begin
			@(negedge clock);
			if (periods >= 200) break;
		end
		foreach (e[k]) `CHK("density", 1'b1, (acc[k] - e[k] <= 6 && e[k] - acc[k] <= 6))
		`CHK("words", periods / 16, words)
		// all filters settled: far more than three data clocks since clear
		foreach (pm[k]) begin
			x = 4096 * pm[k] / 100;
			`CHK("sinc3", 1'b1, (word3[k] - x <= 600 && x - word3[k] <= 600))
			`CHK("cascade", 1'b1, (wordc[k] - 2 * x <= 1200 && 2 * x - wordc[k] <= 1200))
			x = 256 * pm[k] / 100;
			`CHK("sinc2", 1'b1, (word2[k] - x <= 48 && x - word2[k] <= 48))
			`CHK("fast", 1'b1, (wordf[k] - 2 * x <= 96 && 2 * x - wordf[k] <= 96))
		end
	endtask

	// external source: output clock is the external clock halved
	task automatic t_external(input int half);
		ext_half = half;
		sel = 1'b0;
		ext_run = 1'b1;
		t_period(4 * half);
	endtask

	// main sequence
	initial begin
		repeat (2) @(negedge clock);
		reset = 1'b0;
		t_period(10);
		t_density();
		t_external(5);
		t_external(50);
		`CHK("update", 0, bad_upd)
		stop_test();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		stop_test();
	end
endmodule // dsm_bitstream_clock_and_decimation_tb
